/* srts_top.sv */
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "srts_params.svh"
module srts_top import srts_pkg::*; #(
  parameter int CTRL_TICK_CYCLES = `SRTS_CTRL_PERIOD_NS / `SRTS_CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic second_set_select,
  input wire logic third_set_select,
  output logic [11:0] speed_ref_out,
  output logic [11:0] speed_limit_out,
  output logic [1:0] active_set_out
);
  localparam int TW = $clog2(CTRL_TICK_CYCLES + 1);
  localparam int SW = `SRTS_SPEED_W;

  //////////////////////////////////////////////////////////////////////////////
  // contact inputs and control tick
  logic sec_s, thr_s;
  srts_sync #(.WIDTH(1)) u_sync_second (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(second_set_select),
    .sync_out(sec_s)
  );
  srts_sync #(.WIDTH(1)) u_sync_third (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(third_set_select),
    .sync_out(thr_s)
  );

  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic tick;
  always_comb begin
    tick = (tick_cnt == TW'(CTRL_TICK_CYCLES - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file
  logic ramp_time_resolution, vf_control, position_command_source;
  logic [1:0] mode_field;
  logic [15:0] accel_time_first, decel_time_first, accel_time_second;
  logic [15:0] decel_time_second, accel_time_third, decel_time_third;
  logic [SW-1:0] ramp_reference_speed, speed_command;
  logic [15:0] speed_input_gain_calibration;
  logic next_res, next_vf, next_pcs;
  logic [1:0] next_mode;
  logic [15:0] next_a1, next_d1, next_a2, next_d2, next_a3, next_d3, next_gain;
  logic [SW-1:0] next_ref, next_cmd;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wr_en, setup, mapped;
  logic [31:0] status_word, output_word;
  logic [31:0] acc;
  logic [1:0] active_set;
  logic settled, dir_up;
  srts_mode_t mode;

  function automatic logic [15:0] clamp_time(input logic [15:0] v);
    clamp_time = (v > `SRTS_TIME_MAX) ? `SRTS_TIME_MAX : v;
  endfunction
  function automatic logic [SW-1:0] clamp_speed(input logic [SW-1:0] v, input logic no_zero);
    clamp_speed = v;
    if (v > `SRTS_SPEED_MAX) begin
      clamp_speed = `SRTS_SPEED_MAX;
    end else if (no_zero && v < `SRTS_REF_SPEED_MIN) begin
      clamp_speed = `SRTS_REF_SPEED_MIN;
    end
  endfunction

  always_comb begin
    wr_en = psel && penable && pwrite;
    setup = psel && !penable;
    mapped = (paddr <= `SRTS_ADDR_GAIN_CAL) && (paddr[1:0] == 2'b00);
    status_word = {24'h000000, 1'b0, 1'b0, dir_up, settled, 2'b00, active_set};
    output_word = {4'h0, speed_limit_out, 4'h0, speed_ref_out};
    next_res = ramp_time_resolution;
    next_vf = vf_control;
    next_pcs = position_command_source;
    next_mode = mode_field;
    next_a1 = accel_time_first;
    next_d1 = decel_time_first;
    next_a2 = accel_time_second;
    next_d2 = decel_time_second;
    next_a3 = accel_time_third;
    next_d3 = decel_time_third;
    next_ref = ramp_reference_speed;
    next_cmd = speed_command;
    next_gain = speed_input_gain_calibration;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (setup) begin
      next_pslverr = !mapped;
      unique case (paddr)
        `SRTS_ADDR_CTRL: next_prdata = {27'h0000000, position_command_source, vf_control,
                                        mode_field, ramp_time_resolution};
        `SRTS_ADDR_ACCEL1: next_prdata = {16'h0000, accel_time_first};
        `SRTS_ADDR_DECEL1: next_prdata = {16'h0000, decel_time_first};
        `SRTS_ADDR_ACCEL2: next_prdata = {16'h0000, accel_time_second};
        `SRTS_ADDR_DECEL2: next_prdata = {16'h0000, decel_time_second};
        `SRTS_ADDR_ACCEL3: next_prdata = {16'h0000, accel_time_third};
        `SRTS_ADDR_DECEL3: next_prdata = {16'h0000, decel_time_third};
        `SRTS_ADDR_REF_SPEED: next_prdata = {20'h00000, ramp_reference_speed};
        `SRTS_ADDR_SPEED_CMD: next_prdata = {20'h00000, speed_command};
        `SRTS_ADDR_STATUS: next_prdata = status_word;
        `SRTS_ADDR_OUTPUTS: next_prdata = output_word;
        `SRTS_ADDR_GAIN_CAL: next_prdata = {16'h0000, speed_input_gain_calibration};
        default: next_prdata = 32'h00000000;
      endcase
    end else begin
      next_pslverr = pslverr;
    end
    if (wr_en) begin
      unique case (paddr)
        // resolution, mode, V/F and position-source fields move, counts stay
        `SRTS_ADDR_CTRL: begin
          next_res = pwdata[`SRTS_CTRL_RES_BIT];
          next_mode = pwdata[`SRTS_CTRL_MODE_LSB +: 2];
          next_vf = pwdata[`SRTS_CTRL_VF_BIT];
          next_pcs = pwdata[`SRTS_CTRL_PCS_BIT];
        end
        `SRTS_ADDR_ACCEL1: next_a1 = clamp_time(pwdata[15:0]);
        `SRTS_ADDR_DECEL1: next_d1 = clamp_time(pwdata[15:0]);
        `SRTS_ADDR_ACCEL2: next_a2 = clamp_time(pwdata[15:0]);
        `SRTS_ADDR_DECEL2: next_d2 = clamp_time(pwdata[15:0]);
        `SRTS_ADDR_ACCEL3: next_a3 = clamp_time(pwdata[15:0]);
        `SRTS_ADDR_DECEL3: next_d3 = clamp_time(pwdata[15:0]);
        `SRTS_ADDR_REF_SPEED: next_ref = clamp_speed(pwdata[SW-1:0], 1'b1);
        `SRTS_ADDR_SPEED_CMD: next_cmd = clamp_speed(pwdata[SW-1:0], 1'b0);
        `SRTS_ADDR_GAIN_CAL: next_gain = pwdata[15:0];
        default: next_cmd = speed_command;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_time_resolution <= 1'b0;
      vf_control <= 1'b0;
      position_command_source <= 1'b1;
      mode_field <= 2'b00;
      accel_time_first <= `SRTS_TIME_RST;
      decel_time_first <= `SRTS_TIME_RST;
      accel_time_second <= `SRTS_TIME_RST;
      decel_time_second <= `SRTS_DECEL_SAME;
      accel_time_third <= `SRTS_TIME_RST;
      decel_time_third <= `SRTS_DECEL_SAME;
      ramp_reference_speed <= `SRTS_REF_SPEED_RST;
      speed_command <= '0;
      speed_input_gain_calibration <= `SRTS_GAIN_CAL_RST;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      ramp_time_resolution <= next_res;
      vf_control <= next_vf;
      position_command_source <= next_pcs;
      mode_field <= next_mode;
      accel_time_first <= next_a1;
      decel_time_first <= next_d1;
      accel_time_second <= next_a2;
      decel_time_second <= next_d2;
      accel_time_third <= next_a3;
      decel_time_third <= next_d3;
      ramp_reference_speed <= next_ref;
      speed_command <= next_cmd;
      speed_input_gain_calibration <= next_gain;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end
  assign pready = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // set selection and effective time
  logic hold_set;
  logic [1:0] requested_set, next_active_set;
  logic [15:0] accel_sel, decel_raw, decel_sel, time_sel;
  logic [23:0] time_ms, eff_ms;
  logic [31:0] target_acc;

  always_comb begin
    mode = (mode_field == 2'b01) ? SRTS_MODE_TORQUE :
           (mode_field == 2'b10) ? SRTS_MODE_POSITION : SRTS_MODE_SPEED;
    target_acc = {4'h0, speed_command, 16'h0000};
    settled = (acc == target_acc);
    dir_up = (acc < target_acc);
    requested_set = thr_s ? SRTS_SET_THIRD : (sec_s ? SRTS_SET_SECOND : SRTS_SET_FIRST);
    // in position mode with contact-conditional source, defer set change until ramp settles
    hold_set = (mode == SRTS_MODE_POSITION) && !position_command_source && !settled;
    next_active_set = hold_set ? active_set : requested_set;
    accel_sel = accel_time_first;
    decel_raw = decel_time_first;
    if (active_set == SRTS_SET_SECOND) begin
      accel_sel = accel_time_second;
      decel_raw = decel_time_second;
    end else if (active_set == SRTS_SET_THIRD) begin
      accel_sel = accel_time_third;
      decel_raw = decel_time_third;
    end
    decel_sel = ((active_set != SRTS_SET_FIRST) && (decel_raw == `SRTS_DECEL_SAME)) ?
                accel_sel : decel_raw;
    time_sel = dir_up ? accel_sel : decel_sel;
    time_ms = time_sel * (ramp_time_resolution ? `SRTS_MS_PER_COUNT_FINE :
                                                 `SRTS_MS_PER_COUNT_COARSE);
    eff_ms = (vf_control && time_ms <= `SRTS_VF_MIN_MS) ? `SRTS_VF_SUB_MS : time_ms;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_set <= SRTS_SET_FIRST;
    end else begin
      active_set <= next_active_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ramp generator
  logic div_busy, div_done;
  logic [31:0] div_q, step, next_step, next_acc, gap;
  logic [11:0] next_ref_out, next_lim_out;

  srts_divider #(.W(32)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(!div_busy),
    .dividend({4'h0, ramp_reference_speed, 16'h0000}),
    .divisor({8'h00, eff_ms}),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  );

  always_comb begin
    next_step = div_done ? div_q : step;
    next_acc = acc;
    gap = dir_up ? (target_acc - acc) : (acc - target_acc);
    // step per tick, clipped at target
    if (tick && !settled) begin
      if (eff_ms == '0 || gap <= step) begin
        next_acc = target_acc;
      end else begin
        next_acc = dir_up ? acc + step : acc - step;
      end
    end
    // ramp drives reference or torque limit
    next_ref_out = (mode != SRTS_MODE_TORQUE) ? acc[`SRTS_FRAC +: 12] : 12'h000;
    next_lim_out = (mode == SRTS_MODE_TORQUE) ? acc[`SRTS_FRAC +: 12] : 12'h000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 32'h00000000;
      acc <= 32'h00000000;
      speed_ref_out <= 12'h000;
      speed_limit_out <= 12'h000;
    end else begin
      step <= next_step;
      acc <= next_acc;
      speed_ref_out <= next_ref_out;
      speed_limit_out <= next_lim_out;
    end
  end
  assign active_set_out = active_set;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_third_wins;
    @(posedge pclk) disable iff (!presetn)
      (thr_s && !hold_set) |=> (active_set == SRTS_SET_THIRD);
  endproperty
  a_third_wins: assert property (p_third_wins) else $error("third set not taken");

  property p_second_set;
    @(posedge pclk) disable iff (!presetn)
      (sec_s && !thr_s && !hold_set) |=> (active_set == SRTS_SET_SECOND);
  endproperty
  a_second_set: assert property (p_second_set) else $error("second set not taken");

  property p_hold_set;
    @(posedge pclk) disable iff (!presetn)
      hold_set |=> $stable(active_set);
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("set changed while held");

  property p_decel_borrow;
    @(posedge pclk) disable iff (!presetn)
      (active_set == SRTS_SET_THIRD && decel_time_third == `SRTS_DECEL_SAME)
        |-> (decel_sel == accel_time_third);
  endproperty
  a_decel_borrow: assert property (p_decel_borrow) else $error("decel 9999 not mapped");

  property p_vf_floor;
    @(posedge pclk) disable iff (!presetn)
      (vf_control && time_sel <= 16'h0003 && ramp_time_resolution) |-> (eff_ms == 24'h000028);
  endproperty
  a_vf_floor: assert property (p_vf_floor) else $error("vf floor missing");

  property p_no_overshoot;
    @(posedge pclk) disable iff (!presetn)
      (tick && dir_up && $stable(speed_command)) |=> (acc <= $past(target_acc) && acc > $past(acc));
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("ramp step wrong");

  property p_ref_range;
    @(posedge pclk) disable iff (!presetn)
      (ramp_reference_speed >= 12'h001) && (ramp_reference_speed <= 12'hE10);
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference out of range");

  property p_torque_limit;
    @(posedge pclk) disable iff (!presetn)
      (mode == SRTS_MODE_TORQUE) |=> (speed_limit_out == $past(acc[27:16]) && speed_ref_out == 0);
  endproperty
  a_torque_limit: assert property (p_torque_limit) else $error("torque limit wrong");

  property p_res_keeps;
    @(posedge pclk) disable iff (!presetn)
      (ramp_time_resolution != $past(ramp_time_resolution)) |-> $stable(accel_time_first);
  endproperty
  a_res_keeps: assert property (p_res_keeps) else $error("counts changed on rescale");

  property p_gain_kept;
    @(posedge pclk) disable iff (!presetn)
      $changed(ramp_reference_speed) |-> $stable(speed_input_gain_calibration);
  endproperty
  a_gain_kept: assert property (p_gain_kept) else $error("gain moved with reference");
endmodule

/* srts_params.svh */
`ifndef SRTS_PARAMS_SVH
`define SRTS_PARAMS_SVH
`define SRTS_CLK_PERIOD_NS 50
`define SRTS_CTRL_PERIOD_NS 1000000
`define SRTS_ADDR_CTRL 8'h00
`define SRTS_ADDR_ACCEL1 8'h04
`define SRTS_ADDR_DECEL1 8'h08
`define SRTS_ADDR_ACCEL2 8'h0C
`define SRTS_ADDR_DECEL2 8'h10
`define SRTS_ADDR_ACCEL3 8'h14
`define SRTS_ADDR_DECEL3 8'h18
`define SRTS_ADDR_REF_SPEED 8'h1C
`define SRTS_ADDR_SPEED_CMD 8'h20
`define SRTS_ADDR_STATUS 8'h24
`define SRTS_ADDR_OUTPUTS 8'h28
`define SRTS_ADDR_GAIN_CAL 8'h2C
`define SRTS_CTRL_RES_BIT 0
`define SRTS_CTRL_MODE_LSB 1
`define SRTS_CTRL_VF_BIT 3
`define SRTS_CTRL_PCS_BIT 4
`define SRTS_REF_SPEED_RST 12'h5DC
`define SRTS_REF_SPEED_MIN 12'h001
`define SRTS_SPEED_MAX 12'hE10
`define SRTS_TIME_RST 16'h0032
`define SRTS_TIME_MAX 16'h8CA0
`define SRTS_DECEL_SAME 16'h270F
`define SRTS_GAIN_CAL_RST 16'h0000
`define SRTS_MS_PER_COUNT_COARSE 8'h64
`define SRTS_MS_PER_COUNT_FINE 8'h0A
`define SRTS_VF_MIN_MS 24'h00001E
`define SRTS_VF_SUB_MS 24'h000028
`define SRTS_FRAC 16
`define SRTS_SPEED_W 12
`endif

/* srts_pkg.sv */
package srts_pkg;
  typedef enum logic [1:0] {
    SRTS_MODE_SPEED,
    SRTS_MODE_TORQUE,
    SRTS_MODE_POSITION,
    SRTS_MODE_RSVD
  } srts_mode_t;
  typedef enum logic [1:0] {
    SRTS_SET_FIRST,
    SRTS_SET_SECOND,
    SRTS_SET_THIRD
  } srts_set_t;
  typedef enum logic {
    SRTS_DIV_IDLE,
    SRTS_DIV_RUN
  } srts_div_state_t;
endpackage

/* srts_sync.sv */
`timescale 1ns/100ps
module srts_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* srts_divider.sv */
`timescale 1ns/100ps
module srts_divider import srts_pkg::*; #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [W-1:0] quotient
);
  localparam int CW = $clog2(W);
  srts_div_state_t state, next_state;
  logic [W:0] rem, next_rem;
  logic [W-1:0] quo, next_quo, dvs, next_dvs, next_quotient;
  logic [CW-1:0] cnt, next_cnt;
  logic next_done;
  logic [W:0] shifted;
  logic [W:0] trial;

  always_comb begin
    next_state = state;
    next_rem = rem;
    next_quo = quo;
    next_dvs = dvs;
    next_cnt = cnt;
    next_done = 1'b0;
    next_quotient = quotient;
    shifted = {rem[W-1:0], quo[W-1]};
    trial = shifted - {1'b0, dvs};
    unique case (state)
      SRTS_DIV_IDLE: begin
        if (start) begin
          next_state = SRTS_DIV_RUN;
          next_rem = '0;
          next_quo = dividend;
          next_dvs = divisor;
          next_cnt = CW'(W - 1);
        end
      end
      SRTS_DIV_RUN: begin
        // division by zero yields all ones, the fastest ramp
        if (!trial[W]) begin
          next_rem = trial;
          next_quo = {quo[W-2:0], 1'b1};
        end else begin
          next_rem = shifted;
          next_quo = {quo[W-2:0], 1'b0};
        end
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_state = SRTS_DIV_IDLE;
          next_done = 1'b1;
          next_quotient = next_quo;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SRTS_DIV_IDLE;
      rem <= '0;
      quo <= '0;
      dvs <= '0;
      cnt <= '0;
      done <= 1'b0;
      quotient <= '0;
    end else begin
      state <= next_state;
      rem <= next_rem;
      quo <= next_quo;
      dvs <= next_dvs;
      cnt <= next_cnt;
      done <= next_done;
      quotient <= next_quotient;
    end
  end

  assign busy = (state == SRTS_DIV_RUN);
endmodule

/* srts_contact_model.sv */
`timescale 1ns/100ps
// external contact pair: closes one clock after the request, opens on reset
module srts_contact_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_second,
  input wire logic want_third,
  output logic second_set_select,
  output logic third_set_select
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_set_select <= 1'b0;
      third_set_select <= 1'b0;
    end else begin
      second_set_select <= want_second;
      third_set_select <= want_third;
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
`include "srts_params.svh"
module tb_top;
  import srts_pkg::*;
  localparam int TICK = 50;
  typedef struct {
    logic [7:0] addr;
    logic [31:0] val;
  } srts_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic want_second, want_third, second_set_select, third_set_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] speed_ref_out, speed_limit_out;
  logic [1:0] active_set_out;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  srts_row_t rows [10] = '{'{8'h00, 32'h10}, '{8'h04, 32'h32}, '{8'h08, 32'h32},
    '{8'h0C, 32'h32}, '{8'h10, 32'h270F}, '{8'h14, 32'h32}, '{8'h18, 32'h270F},
    '{8'h1C, 32'h5DC}, '{8'h20, 32'h0}, '{8'h2C, 32'h0}};
  logic [1:0] sel_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};

  srts_top #(.CTRL_TICK_CYCLES(TICK)) u_srts_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .second_set_select(second_set_select), .third_set_select(third_set_select),
    .speed_ref_out(speed_ref_out), .speed_limit_out(speed_limit_out),
    .active_set_out(active_set_out));
  srts_contact_model u_srts_contact_model (.pclk(pclk), .presetn(presetn),
    .want_second(want_second), .want_third(want_third),
    .second_set_select(second_set_select), .third_set_select(third_set_select));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles >= 60000) begin
      mismatches++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // value must lie strictly between lo and hi: ramp in progress
  task automatic chk_rng(input logic [11:0] got, input logic [11:0] lo, input logic [11:0] hi);
    num_checks++;
    // an unknown value must fail, not slip through the range test
    if ((^got === 1'bx) || !(got > lo && got < hi)) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge pclk);
  endtask

  task automatic pick(input logic s2, input logic s3);
    @(posedge pclk);
    want_second <= s2;
    want_third <= s3;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want_second = 1'b0;
    want_third = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({20'h0, speed_ref_out}, 32'h0);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0);
      chk(rd, rows[i].val);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    // speed mode, fine resolution, 10 ms up and 20 ms down
    apb(1'b1, 8'h2C, 32'h1234);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h1C, 32'h3E8);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(4);
    chk_rng(speed_ref_out, 12'h0, 12'h3E8);
    chk({20'h0, speed_limit_out}, 32'h0);
    ticks(10);
    chk({20'h0, speed_ref_out}, 32'h3E8);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h000003E8);
    apb(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h1234);
    apb(1'b1, 8'h20, 32'h0);
    ticks(12);
    chk_rng(speed_ref_out, 12'h0, 12'h3E8);
    ticks(25);
    chk({20'h0, speed_ref_out}, 32'h0);
    // coarse resolution: the same count now means 100 ms
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(20);
    chk_rng(speed_ref_out, 12'h0, 12'h190);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    ticks(30);
    // set selection, second and third with instant accel
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h18, 32'h5);
    for (int i = 0; i < 4; i++) begin
      pick(i[0], i[1]);
      repeat (6) @(posedge pclk);
      chk({30'h0, active_set_out}, {30'h0, sel_exp[i]});
    end
    pick(1'b1, 1'b0);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(3);
    chk({20'h0, speed_ref_out}, 32'h3E8);
    apb(1'b1, 8'h20, 32'h0);
    ticks(3);
    chk({20'h0, speed_ref_out}, 32'h0);
    pick(1'b0, 1'b1);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(3);
    chk({20'h0, speed_ref_out}, 32'h3E8);
    apb(1'b1, 8'h20, 32'h0);
    ticks(3);
    chk_rng(speed_ref_out, 12'h0, 12'h3E8);
    ticks(60);
    // V/F: 10 ms is raised to 40 ms
    pick(1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h9);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(15);
    chk_rng(speed_ref_out, 12'h0, 12'h3E8);
    ticks(40);
    chk({20'h0, speed_ref_out}, 32'h3E8);
    apb(1'b1, 8'h20, 32'h0);
    ticks(50);
    // torque mode: ramp shows as the speed limit
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(4);
    chk_rng(speed_limit_out, 12'h0, 12'h3E8);
    chk({20'h0, speed_ref_out}, 32'h0);
    ticks(12);
    chk({20'h0, speed_limit_out}, 32'h3E8);
    apb(1'b1, 8'h20, 32'h0);
    ticks(30);
    // position mode, contact-conditional: set switch waits for settle
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b1, 8'h04, 32'h64);
    apb(1'b1, 8'h20, 32'h3E8);
    ticks(2);
    pick(1'b0, 1'b1);
    repeat (10) @(posedge pclk);
    chk({30'h0, active_set_out}, 32'h0);
    chk_rng(speed_ref_out, 12'h0, 12'h3E8);
    apb(1'b1, 8'h04, 32'h0);
    ticks(3);
    chk({30'h0, active_set_out}, 32'h2);
    complete_run();
  end
endmodule
